/* logic/acb_serializer.sv */
`timescale 1ns/1ns
// ==========================================================
// link-domain serializer: frames one result onto the shared lines
module acb_serializer import acb_pkg::*; (
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic req_tgl,
  input wire logic [RESULT_W-1:0] word,
  input wire logic frame8,
  input wire logic grant_ok,
  output logic ack_tgl,
  output logic data_o,
  output logic sync_o,
  output logic busy_o,
  output logic bus_clk_o
);
  acb_ser_state_t state_reg; // serializer state
  logic [RESULT_W-1:0] shift_reg; // word being shifted, msb first
  logic [3:0] idx_reg; // index of the bit on the line
  logic phase_reg; // bit clock level
  logic ack_reg; // handshake answer toggle
  logic data_reg;
  logic sync_reg;
  logic pending; // a word waits in the other domain
  assign pending = req_tgl != ack_reg;

  // ==========================================================
  // free-running bit clock, half the link rate
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      phase_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= ~phase_reg;
    end
  end

  // ==========================================================
  // frame sequencer, bits change when the bit clock falls
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      state_reg <= SER_IDLE;
      shift_reg <= '0;
      idx_reg <= 4'h0;
      ack_reg <= 1'b0;
      data_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        // take the word, it stays stable until ack returns
        SER_IDLE:
        begin
          if (pending)
          begin
            shift_reg <= word;
            ack_reg <= ~ack_reg;
            state_reg <= SER_WAIT;
          end
        end
        // hold off until the read grant allows us on the bus
        SER_WAIT:
        begin
          if (grant_ok && phase_reg)
          begin
            state_reg <= SER_SHIFT;
            data_reg <= shift_reg[RESULT_W-1];
            shift_reg <= {shift_reg[RESULT_W-2:0], 1'b0};
            sync_reg <= 1'b1;
            idx_reg <= 4'h0;
          end
        end
        // one bit per bit clock period
        SER_SHIFT:
        begin
          if (phase_reg)
          begin
            if (idx_reg == LAST_BIT_IDX)
            begin
              state_reg <= SER_IDLE;
              data_reg <= 1'b0;
              sync_reg <= 1'b0;
            end
            else
            begin
              idx_reg <= idx_reg + 4'h1;
              data_reg <= shift_reg[RESULT_W-1];
              shift_reg <= {shift_reg[RESULT_W-2:0], 1'b0};
              // byte frames restart sync at the second byte
              sync_reg <= frame8 && (idx_reg + 4'h1 == BYTE2_BIT_IDX);
            end
          end
        end
        default:
        begin
          state_reg <= SER_IDLE;
        end
      endcase
    end
  end

  assign ack_tgl = ack_reg;
  assign data_o = data_reg;
  assign sync_o = sync_reg;
  assign busy_o = state_reg == SER_SHIFT;
  assign bus_clk_o = phase_reg;

  // ==========================================================
  // checks of the frame shape
  property p_frame_len;
    @(posedge link_clk) disable iff (!link_rst_n)
    $rose(busy_o) |-> ##31 busy_o ##1 !busy_o;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("bus occupied not held for one 16-bit frame");
  property p_sync8;
    @(posedge link_clk) disable iff (!link_rst_n)
    ($rose(busy_o) && frame8 && $stable(frame8)) |-> sync_o ##16 sync_o;
  endproperty
  a_sync8: assert property (p_sync8)
    else $error("byte frame sync missing at second byte");
  property p_sync16;
    @(posedge link_clk) disable iff (!link_rst_n)
    ($rose(busy_o) && !frame8) |-> sync_o ##2 !sync_o [*8];
  endproperty
  a_sync16: assert property (p_sync16)
    else $error("word frame sync not a single bit");
  property p_bit_clk;
    @(posedge link_clk) disable iff (!link_rst_n)
    $past(link_rst_n) |-> bus_clk_o != $past(bus_clk_o);
  endproperty
  a_bit_clk: assert property (p_bit_clk)
    else $error("bit clock stopped");
endmodule : acb_serializer

/* logic/acb_sync3.sv */
`timescale 1ns/1ns
// ==========================================================
// three-flop synchronizer per bit, change accepted when stages two and three agree
module acb_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  // one chain per bit
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1_reg; // first stage, read only by s2
      logic s2_reg;
      logic s3_reg;
      logic out_reg; // filtered value
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          out_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= d[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          // only a value seen twice in a row is taken
          if (s2_reg == s3_reg)
          begin
            out_reg <= s3_reg;
          end
        end
      end
      assign q[i] = out_reg;
    end
  endgenerate
endmodule : acb_sync3

/* logic/acb_top.sv */
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
// ==========================================================
// Overview of operation
// - chain mode strap enables shared bus gating
// - latency strap zero sends current, else previous
// - only the granted device drives data, sync
// - clock driver strap drives bit clock continuously
// - clock source strap enables internal clock generator
// - generated clock feeds all, not shared bus
// - frame of sixteen or two eight-bit bytes
// - serial bit rate up to 200 mbps
// - sixteen-bit results, at most 2 msps
// - bus occupied high while driving data
// - in chain mode, drive data only while read grant low
module acb_top import acb_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chain_mode_select,
  input wire logic latency_select,
  input wire logic clock_driver_select,
  input wire logic clock_source_select,
  input wire logic diff_conversion_start,
  input wire logic cmos_conversion_start,
  input wire logic [RESULT_W-1:0] sample_data,
  output logic gen_clk_out,
  input wire logic link_clk,
  input wire logic read_grant_n,
  output logic serial_result_out,
  output logic serial_result_oe,
  output logic frame_sync_out,
  output logic frame_sync_oe,
  output logic bus_clk_out,
  output logic bus_clk_oe,
  output logic bus_occupied
);
  // ==========================================================
  // register state
  logic [2:0] ctrl_reg; // frame8, cmos source, enable
  logic ovr_reg; // sticky: result dropped while one was pending
  logic [RESULT_W-1:0] result_reg; // last sampled result
  logic [RESULT_W-1:0] held_reg; // result kept back for latency mode
  logic [RESULT_W-1:0] tx_word_reg; // word offered to the link domain
  logic [15:0] count_reg; // accepted conversions
  logic req_reg; // handshake request toggle
  logic start_prev_reg; // previous start level
  logic [5:0] guard_reg; // cycles left before next start
  logic gen_div_reg; // internal clock divider

  // synchronized pins and crossings on aclk
  logic [7:0] a_sync;
  logic chain_s, lat_s, drv_s, src_s, diff_s, cmos_s, busy_s, ack_s;
  logic ser_ack; // answer toggle from the link side
  logic [3:0] lrst_hold_reg; // aclk cycles left holding the link side in reset
  acb_sync3 #(.W(8)) u_sync_a (
    .clk(aclk),
    .rst_n(aresetn),
    .d({chain_mode_select, latency_select, clock_driver_select, clock_source_select,
        diff_conversion_start, cmos_conversion_start, bus_occupied, ser_ack}),
    .q(a_sync)
  );
  assign {chain_s, lat_s, drv_s, src_s, diff_s, cmos_s, busy_s, ack_s} = a_sync;

  // link domain reset and synchronized inputs
  logic [2:0] lrst_pipe; // reset release into the link domain
  logic link_rst_n;
  logic [3:0] l_sync;
  logic req_l, frame8_l, chain_l, grant_n_l;
  logic ser_data;
  logic ser_sync;
  logic grant_ok; // allowed onto the shared lines

  // handshake and start detection
  logic pending; // word waits for the link side
  logic start_lvl; // chosen start source
  logic accept; // a conversion is taken this cycle
  logic [RESULT_W-1:0] send_word;

  // bus handshake state
  logic aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] rdata_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic do_write;

  // ==========================================================
  // link reset stretched on aclk, a short reset pulse could fall between link edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lrst_hold_reg <= LINK_RST_HOLD;
    end
    else if (lrst_hold_reg != 4'h0)
    begin
      lrst_hold_reg <= lrst_hold_reg - 4'h1;
    end
  end
  // release passes three link flops, which have no reset of their own
  always_ff @(posedge link_clk)
  begin
    lrst_pipe <= {lrst_pipe[1:0], lrst_hold_reg == 4'h0};
  end
  assign link_rst_n = lrst_pipe[2];

  acb_sync3 #(.W(4)) u_sync_l (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d({req_reg, ctrl_reg[CTRL_FRAME8_BIT], chain_mode_select, read_grant_n}),
    .q(l_sync)
  );
  assign {req_l, frame8_l, chain_l, grant_n_l} = l_sync;

  // outside chain mode the grant pin is ignored
  assign grant_ok = !chain_l || !grant_n_l;

  acb_serializer u_ser (
    .link_clk(link_clk),
    .link_rst_n(link_rst_n),
    .req_tgl(req_l),
    .word(tx_word_reg),
    .frame8(frame8_l),
    .grant_ok(grant_ok),
    .ack_tgl(ser_ack),
    .data_o(ser_data),
    .sync_o(ser_sync),
    .busy_o(bus_occupied),
    .bus_clk_o(bus_clk_out)
  );

  // data and sync released to high impedance unless driving a granted frame
  assign serial_result_out = ser_data;
  assign frame_sync_out = ser_sync;
  assign serial_result_oe = bus_occupied && grant_ok;
  assign frame_sync_oe = bus_occupied && grant_ok;
  // bit clock strap is static, sampled once stable
  assign bus_clk_oe = drv_s;

  // ==========================================================
  // internal clock: aclk divided by two, on its own pin only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gen_div_reg <= 1'b0;
    end
    else if (src_s)
    begin
      gen_div_reg <= ~gen_div_reg;
    end
    else
    begin
      gen_div_reg <= 1'b0;
    end
  end
  assign gen_clk_out = gen_div_reg;

  // ==========================================================
  // conversion start: rising edge of the chosen source, 2 msps guard
  assign start_lvl = ctrl_reg[CTRL_CMOS_SRC_BIT] ? cmos_s : diff_s;
  assign accept = start_lvl && !start_prev_reg && ctrl_reg[CTRL_ENABLE_BIT]
                  && guard_reg == 6'h0;
  assign pending = req_reg != ack_s;
  assign send_word = lat_s ? held_reg : sample_data;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_prev_reg <= 1'b0;
      guard_reg <= 6'h0;
    end
    else
    begin
      start_prev_reg <= start_lvl;
      if (accept)
      begin
        guard_reg <= CONV_GUARD_LOAD;
      end
      else if (guard_reg != 6'h0)
      begin
        guard_reg <= guard_reg - 6'h1;
      end
    end
  end

  // ==========================================================
  // result capture and hand-over to the link domain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_reg <= '0;
      held_reg <= '0;
      tx_word_reg <= '0;
      req_reg <= 1'b0;
      count_reg <= 16'h0;
    end
    else if (accept)
    begin
      result_reg <= sample_data;
      held_reg <= sample_data;
      count_reg <= count_reg + 16'h1;
      // the word only changes while no request is open
      if (!pending)
      begin
        tx_word_reg <= send_word;
        req_reg <= ~req_reg;
      end
    end
  end

  // ==========================================================
  // overrun flag, a new drop wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovr_reg <= 1'b0;
    end
    else if (accept && pending)
    begin
      ovr_reg <= 1'b1;
    end
    else if (do_write && awaddr_reg == ADDR_STATUS && wstrb_reg[0] && wdata_reg[ST_OVR_BIT])
    begin
      ovr_reg <= 1'b0;
    end
  end

  // ==========================================================
  // axi4-lite write: address and data in either order, response after both
  assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        // only the four word offsets are mapped
        bresp_reg <= (awaddr_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // control register, low byte lane only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= CTRL_RESET;
    end
    else if (do_write && awaddr_reg == ADDR_CTRL && wstrb_reg[0])
    begin
      ctrl_reg <= wdata_reg[2:0];
    end
  end

  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = !w_got_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ==========================================================
  // axi4-lite read, answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: rdata_reg <= {29'h0, ctrl_reg};
        ADDR_STATUS: rdata_reg <= {25'h0, ovr_reg, src_s, drv_s, lat_s, chain_s, pending,
                                   busy_s};
        ADDR_RESULT: rdata_reg <= {16'h0, result_reg};
        ADDR_COUNT: rdata_reg <= {16'h0, count_reg};
        default:
        begin
          rdata_reg <= 32'h0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ==========================================================
  // checks
  property p_guard;
    @(posedge aclk) disable iff (!aresetn)
    accept |=> !accept [*8];
  endproperty
  a_guard: assert property (p_guard)
    else $error("conversion accepted inside the 500 ns period");
  property p_guard_load;
    @(posedge aclk) disable iff (!aresetn)
    accept |=> guard_reg == CONV_GUARD_LOAD;
  endproperty
  a_guard_load: assert property (p_guard_load)
    else $error("conversion guard not loaded to 49");
  property p_latency_word;
    @(posedge aclk) disable iff (!aresetn)
    (accept && !pending) |=> (req_reg != $past(req_reg))
      && (tx_word_reg == ($past(lat_s) ? $past(held_reg) : $past(sample_data)));
  endproperty
  a_latency_word: assert property (p_latency_word)
    else $error("wrong result word handed to the link");
  property p_overrun;
    @(posedge aclk) disable iff (!aresetn)
    (accept && pending) |=> ovr_reg && $stable(tx_word_reg);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("dropped result not flagged");
  property p_gen_clk;
    @(posedge aclk) disable iff (!aresetn)
    (src_s && $past(src_s)) |-> gen_clk_out != $past(gen_clk_out);
  endproperty
  a_gen_clk: assert property (p_gen_clk)
    else $error("internal clock not toggling");
  property p_grant;
    @(posedge link_clk) disable iff (!link_rst_n)
    $rose(bus_occupied) |-> $past(grant_ok);
  endproperty
  a_grant: assert property (p_grant)
    else $error("frame started without grant");
  property p_bresp;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response late");
  property p_rhold;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read answer dropped before taken");
  c_frame: cover property (@(posedge link_clk) disable iff (!link_rst_n) $rose(bus_occupied));
  c_frame8: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    $rose(bus_occupied) && frame8_l);
  c_overrun: cover property (@(posedge aclk) disable iff (!aresetn) accept && pending);
  c_latency: cover property (@(posedge aclk) disable iff (!aresetn) accept && lat_s);
endmodule : acb_top

/* pkg/acb_pkg.sv */
// ==========================================================
// shared constants of the cascade output bus block
package acb_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RESULT = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hC;
  // control register fields and reset value
  localparam int CTRL_FRAME8_BIT = 0;
  localparam int CTRL_CMOS_SRC_BIT = 1;
  localparam int CTRL_ENABLE_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  // status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_CHAIN_BIT = 2;
  localparam int ST_LAT_BIT = 3;
  localparam int ST_DRV_BIT = 4;
  localparam int ST_SRC_BIT = 5;
  localparam int ST_OVR_BIT = 6;
  // result word and frame layout
  localparam int RESULT_W = 16;
  localparam logic [3:0] LAST_BIT_IDX = 4'hF;
  localparam logic [3:0] BYTE2_BIT_IDX = 4'h8;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing: 10 ns clock, 2 msps gives a 500 ns least conversion period
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_PERIOD_NS = 500;
  localparam int CONV_CYCLES = (CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] CONV_GUARD_LOAD = 6'(CONV_CYCLES - 1);
  // aclk cycles the link side stays in reset after release, spans three link edges
  localparam logic [3:0] LINK_RST_HOLD = 4'hF;
  // one bit per two link clocks, so a 200 mbps line needs link clock >= 400 mhz
  localparam int BIT_RATE_MAX_MBPS = 200;
  localparam int LINK_CYC_PER_BIT = 2;
  // serializer states
  typedef enum logic [1:0] {SER_IDLE, SER_WAIT, SER_SHIFT} acb_ser_state_t;
endpackage : acb_pkg

/* test/acb_rx_model.sv */
`timescale 1ns/1ns
// ==========================================================
// receiver model: frames words on the shared clock and sync
module acb_rx_model (
  input wire logic bclk,
  input wire logic sdata,
  input wire logic sync,
  output logic [15:0] word,
  output int nwords,
  output int nsync
);
  logic [15:0] sh; // incoming bits, msb first
  int cnt; // bits of the current word
  initial
  begin
    nwords = 0;
    nsync = 0;
    cnt = 0;
    word = 16'h0000;
  end
  // capture on the rising shared clock, sync opens a word or its low byte
  always @(posedge bclk)
  begin
    sh = {sh[14:0], sdata};
    if (sync) nsync++;
    if (sync && cnt != 8) cnt = 1;
    else if (cnt != 0) cnt++;
    if (cnt == 16)
    begin
      word = sh;
      nwords++;
      cnt = 0;
    end
  end
endmodule : acb_rx_model

/* test/tb_top.sv */
`timescale 1ns/1ns
// ==========================================================
// bench: one task per scenario, receiver model on the shared lines
module tb_top import acb_pkg::*;;
  logic aclk, aresetn, link_clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic chain_mode_select, latency_select, clock_driver_select, clock_source_select;
  logic diff_conversion_start, cmos_conversion_start, read_grant_n, gen_clk_out;
  logic serial_result_out, serial_result_oe, frame_sync_out, frame_sync_oe;
  logic bus_clk_out, bus_clk_oe, bus_occupied;
  logic [3:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs_q, bs_q;
  logic [RESULT_W-1:0] sample_data, word;
  int err_count = 0, n_tests = 0, nwords, nsync, occ = 0, noe = 0, n0, s0, o0, e0;
  // released lines: clock stands low, sync terminated low, data inverted
  wire logic bclk_w = bus_clk_oe ? bus_clk_out : 1'b0;
  wire logic sy_w = frame_sync_oe ? frame_sync_out : 1'b0;
  wire logic sd_w = serial_result_oe ? serial_result_out : ~serial_result_out;
  acb_top u_acb_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .chain_mode_select, .latency_select, .clock_driver_select, .clock_source_select,
    .diff_conversion_start, .cmos_conversion_start, .sample_data, .gen_clk_out, .link_clk,
    .read_grant_n, .serial_result_out, .serial_result_oe, .frame_sync_out, .frame_sync_oe,
    .bus_clk_out, .bus_clk_oe, .bus_occupied);
  acb_rx_model u_acb_rx_model (.bclk(bclk_w), .sdata(sd_w), .sync(sy_w), .word, .nwords,
    .nsync);
  // clocks: 10 ns system, 32 ns link with an unrelated phase
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial
  begin
    link_clk = 1'b0;
    #3;
    forever #16 link_clk = ~link_clk;
  end
  // link cycles with the bus held and with data driven
  always @(posedge link_clk)
  begin
    if (bus_occupied) occ++;
    if (serial_result_oe) noe++;
  end
  // ==========================================================
  // compare, verdict and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      b = s_axi_bvalid;
      bs_q = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    while (!b);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    logic t, r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      t = s_axi_arready;
      r = s_axi_rvalid;
      rd_q = s_axi_rdata;
      rs_q = s_axi_rresp;
      @(posedge aclk);
      if (t) s_axi_arvalid <= 1'b0;
    end
    while (!r);
    s_axi_rready <= 1'b0;
  endtask : rd
  // one start pulse, held past the guard before the next
  task automatic conv(input logic [15:0] s, input logic cm);
    n0 = nwords;
    s0 = nsync;
    o0 = occ;
    e0 = noe;
    @(posedge aclk);
    sample_data <= s;
    diff_conversion_start <= !cm;
    cmos_conversion_start <= cm;
    repeat (10) @(posedge aclk);
    diff_conversion_start <= 1'b0;
    cmos_conversion_start <= 1'b0;
    repeat (60) @(posedge aclk);
  endtask : conv
  task automatic wait_word;
    for (int i = 0; i < 300 && nwords == n0; i++) @(posedge link_clk);
    repeat (8) @(posedge aclk);
  endtask : wait_word
  // ==========================================================
  // scenarios
  task automatic t_regs;
    rd(ADDR_CTRL);
    chk(rd_q, 32'(CTRL_RESET));
    rd(4'h2);
    chk({rd_q[29:0], rs_q}, {30'h0, RESP_SLVERR});
    rd(ADDR_STATUS);
    chk(rd_q, 32'h0000_0014);
    chk({31'h0, bus_clk_oe}, 32'h1);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_frame;
    conv(16'hA5C3, 1'b0);
    wait_word;
    chk({16'h0, word}, 32'hA5C3);
    chk(32'(nsync - s0), 32'h1);
    chk(32'(occ - o0), 32'h20);
    rd(ADDR_RESULT);
    chk(rd_q, 32'hA5C3);
    $display("t_frame done");
  endtask : t_frame
  task automatic t_lat;
    latency_select <= 1'b1;
    repeat (10) @(posedge aclk);
    conv(16'h1234, 1'b0);
    wait_word;
    chk({16'h0, word}, 32'hA5C3);
    latency_select <= 1'b0;
    read_grant_n <= 1'b1;
    repeat (10) @(posedge aclk);
    conv(16'h5678, 1'b0);
    repeat (100) @(posedge link_clk);
    chk(32'(nwords - n0), 32'h0);
    chk(32'(noe - e0), 32'h0);
    // second word waits in the handshake, third is dropped
    conv(16'h9999, 1'b0);
    conv(16'h7777, 1'b0);
    rd(ADDR_STATUS);
    chk(rd_q, 32'h0000_0056);
    wr(ADDR_STATUS, 32'h40);
    read_grant_n <= 1'b0;
    wait_word;
    chk({16'h0, word}, 32'h5678);
    n0 = nwords;
    wait_word;
    chk({16'h0, word}, 32'h9999);
    $display("t_lat done");
  endtask : t_lat
  task automatic t_mode;
    wr(ADDR_CTRL, 32'h5);
    chk({30'h0, bs_q}, {30'h0, RESP_OKAY});
    conv(16'hBEEF, 1'b0);
    wait_word;
    chk({16'h0, word}, 32'hBEEF);
    chk(32'(nsync - s0), 32'h2);
    wr(ADDR_CTRL, 32'h6);
    chain_mode_select <= 1'b0;
    read_grant_n <= 1'b1;
    repeat (10) @(posedge aclk);
    conv(16'h0F0F, 1'b1);
    wait_word;
    chk({16'h0, word}, 32'h0F0F);
    rd(ADDR_COUNT);
    chk(rd_q, 32'h7);
    $display("t_mode done");
  endtask : t_mode
  task automatic t_straps;
    logic g;
    clock_driver_select <= 1'b0;
    clock_source_select <= 1'b1;
    repeat (10) @(negedge aclk);
    chk({31'h0, bus_clk_oe}, 32'h0);
    g = gen_clk_out;
    @(negedge aclk);
    chk({31'h0, gen_clk_out}, {31'h0, ~g});
    rd(ADDR_STATUS);
    chk(rd_q, 32'h0000_0020);
    clock_source_select <= 1'b0;
    repeat (10) @(negedge aclk);
    chk({31'h0, gen_clk_out}, 32'h0);
    @(negedge aclk);
    chk({31'h0, gen_clk_out}, 32'h0);
    rd(ADDR_STATUS);
    chk(rd_q, 32'h0);
    $display("t_straps done");
  endtask : t_straps
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sample_data} = '0;
    {latency_select, diff_conversion_start, cmos_conversion_start, read_grant_n} = '0;
    {chain_mode_select, clock_driver_select, clock_source_select} = 3'h6;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (20) @(posedge aclk);
    t_regs;
    t_frame;
    t_lat;
    t_mode;
    t_straps;
    test_done;
  end
  initial
  begin
    #200000;
    err_count++;
    test_done;
  end
endmodule : tb_top
